//--- core/mees_core.sv
// Error-checking memory controller core: check bits, correction, status registers.
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module mees_core
(
    input  wire logic                  sys_clk,
    input  wire logic                  rstn,
    input  wire logic                  clk_en,
    input  wire logic [11:0]           reg_addr,
    input  wire logic [31:0]           reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output var  logic [31:0]           reg_rdata,
    input  wire logic                  wr_valid,
    input  wire logic [31:0]           wr_data,
    output var  logic                  arr_wr_valid,
    output var  logic [38:0]           arr_wr_word,
    input  wire mees_pkg::mees_rd_t    rd_in,
    output var  mees_pkg::mees_rdout_t rd_out,
    input  wire mees_pkg::mees_req_t   req,
    input  wire mees_pkg::mees_xlate_t xlate,
    input  wire logic [2:0]            modules_installed,
    input  wire logic                  cpu_req,
    input  wire logic                  bus_req,
    input  wire logic                  bus_active,
    output var  logic                  cpu_grant,
    output var  logic                  bus_grant,
    input  wire logic                  map_valid,
    input  wire logic [17:0]           map_addr,
    output var  logic                  map_phys_valid,
    output var  logic [23:0]           map_phys_addr,
    output var  logic                  req_io_region,
    output var  logic [1:0]            req_bank,
    output var  logic                  translation_enable,
    output var  logic                  diagnostic_mode_bit,
    output var  logic                  cpu_error_summary,
    output var  logic                  bus_error_summary,
    output var  logic                  bus_timeout_force
);

    // =========================================================================
    // Register state
    logic [6:0]  syndrome_q;
    logic [31:0] cpu_reg_q;
    logic [31:0] bus_reg_q;
    logic [14:0] map_q [512];
    logic [31:0] cpu_set;
    logic [31:0] bus_set;
    logic [31:0] cpu_clr;
    logic [31:0] bus_clr;
    logic        wr_cpu_reg;
    logic        data_err_cpu;
    logic        data_err_bus;
    logic        bus_sum_q;

    logic suppress_corrected_report;
    logic correction_disable;
    logic force_xlate_parity_fault;
    logic [6:0] diag_checks;
    assign suppress_corrected_report = cpu_reg_q[mees_pkg::POS_SUPPRESS];
    assign correction_disable        = cpu_reg_q[mees_pkg::POS_CORRECTION_DISABLE];
    assign force_xlate_parity_fault  = cpu_reg_q[mees_pkg::POS_FORCE_PAR];
    assign diag_checks               = cpu_reg_q[6:0];

    // =========================================================================
    // Write path
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            arr_wr_valid <= 1'b0;
            arr_wr_word  <= 39'h00_0000_0000;
        end
        else if (clk_en)
        begin
            arr_wr_valid <= wr_valid;
            if (wr_valid)
            begin
                // Diagnostic mode lets software plant chosen check bits.
                if (cpu_reg_q[mees_pkg::POS_DIAG])
                    arr_wr_word <= {diag_checks, wr_data};
                else
                    arr_wr_word <= {mees_pkg::mees_check(wr_data), wr_data};
            end
        end
    end

    // =========================================================================
    // Read path: syndrome, classification, correction and rotation
    logic [31:0] rd_raw;
    logic [6:0]  rd_syn;
    logic [31:0] rd_mask;
    logic        rd_single;
    logic        rd_uncorr;
    logic        rd_any;
    logic [31:0] rd_fixed;
    logic [4:0]  rot_bits;

    always_comb
    begin
        rd_raw    = rd_in.word[31:0];
        rd_syn    = rd_in.word[38:32] ^ mees_pkg::mees_check(rd_raw);
        rd_mask   = mees_pkg::mees_flip(rd_syn);
        // A lone check-bit flip is also a single error; data needs no fix then.
        rd_single = rd_in.valid && ($countones(rd_syn) == 1 || rd_mask != 32'h0000_0000);
        rd_any    = rd_in.valid && rd_syn != 7'h00;
        rd_uncorr = rd_any && !rd_single;
        rd_fixed  = correction_disable ? rd_raw : (rd_raw ^ rd_mask);
        rot_bits  = {rd_in.byte_ofs, 3'h0};
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            rd_out <= '0;
        else if (clk_en)
        begin
            rd_out.valid <= rd_in.valid;
            rd_out.abort <= rd_uncorr;
            rd_out.data  <= (rd_fixed >> rot_bits) | (rd_fixed << (6'd32 - {1'b0, rot_bits}));
        end
    end

    // =========================================================================
    // Address decode and arbitration
    logic in_io;
    logic in_adapter;
    logic missing;
    logic [3:0] module_no;
    always_comb
    begin
        in_io      = req.addr >= mees_pkg::IO_BASE;
        in_adapter = req.addr >= mees_pkg::ADAPTER_BASE;
        module_no  = req.addr[mees_pkg::MODULE_SHIFT +: 4];
        // Installed count is clamped; more than five modules cannot exist.
        missing    = !in_io && (module_no >= {1'b0,
                     (modules_installed > mees_pkg::MAX_MODULES) ?
                     mees_pkg::MAX_MODULES : modules_installed});
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            req_io_region <= 1'b0;
            req_bank      <= 2'h0;
        end
        else if (clk_en && req.valid)
        begin
            req_io_region <= in_io;
            req_bank      <= req.addr[19:18];
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cpu_grant <= 1'b0;
            bus_grant <= 1'b0;
        end
        else if (clk_en)
        begin
            // Peripheral devices win; they may be tied to moving media.
            bus_grant <= bus_req;
            cpu_grant <= cpu_req && !bus_req && !bus_active;
        end
    end

    // =========================================================================
    // Peripheral bus map
    always_ff @(posedge sys_clk)
    begin
        if (clk_en && reg_wr && reg_addr >= mees_pkg::OFS_MAP_BASE)
            map_q[reg_addr[10:2]] <= reg_wdata[14:0];
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            map_phys_valid <= 1'b0;
            map_phys_addr  <= 24'h000000;
        end
        else if (clk_en)
        begin
            map_phys_valid <= map_valid;
            // The map stays active whatever the translation enable says.
            if (map_valid)
                map_phys_addr <= {map_q[map_addr[17:mees_pkg::MAP_PAGE_LSB]],
                                  map_addr[mees_pkg::MAP_PAGE_LSB-1:0]};
        end
    end

    // =========================================================================
    // Error event collection
    logic cpu_rd;
    logic bus_rd;
    logic xl_cpu;
    logic xl_bus;
    logic xl_parity;
    always_comb
    begin
        cpu_rd    = rd_in.valid && !rd_in.from_bus;
        bus_rd    = rd_in.valid && rd_in.from_bus;
        xl_cpu    = xlate.valid && !xlate.bus_side;
        xl_bus    = xlate.valid && xlate.bus_side;
        xl_parity = xlate.parity || force_xlate_parity_fault;
        cpu_set   = 32'h0000_0000;
        bus_set   = 32'h0000_0000;
        cpu_set[mees_pkg::POS_UNCORR] = cpu_rd && rd_uncorr;
        cpu_set[mees_pkg::POS_CORR]   = cpu_rd && rd_single && !correction_disable
                                        && !suppress_corrected_report;
        cpu_set[mees_pkg::POS_MODIFY]  = xl_cpu && xlate.no_modify;
        cpu_set[mees_pkg::POS_DENIED]  = xl_cpu && xlate.denied && cpu_reg_q[mees_pkg::POS_XLATE_EN]
                                         && !xl_parity;
        cpu_set[mees_pkg::POS_MISS]    = xl_cpu && xlate.miss;
        cpu_set[mees_pkg::POS_PARITY]  = xl_cpu && xl_parity;
        cpu_set[mees_pkg::POS_INVALID] = xl_cpu && xlate.invalid;
        cpu_set[mees_pkg::POS_ILLEGAL] = req.valid && !req.from_bus && req.illegal_op;
        cpu_set[mees_pkg::POS_PAGE_CROSS] = req.valid && !req.from_bus && req.write
                                            && req.write_check && req.crosses_page;
        cpu_set[mees_pkg::POS_ADAPTER] = req.valid && !req.from_bus && in_adapter;
        cpu_set[mees_pkg::POS_BUS_BUSY] = req.valid && !req.from_bus && in_io
                                          && !in_adapter && bus_active;
        cpu_set[mees_pkg::POS_MISSING] = req.valid && !req.from_bus && missing;
        bus_set[mees_pkg::POS_UNCORR]  = bus_rd && rd_uncorr;
        bus_set[mees_pkg::POS_MISSING] = req.valid && req.from_bus && missing;
        bus_set[mees_pkg::POS_PARITY]  = xl_bus && xl_parity;
        bus_set[mees_pkg::POS_INVALID] = xl_bus && xlate.two_cycle_write
                                         && xlate.invalid;
        data_err_cpu = cpu_rd && rd_any;
        data_err_bus = bus_rd && rd_any;
    end

    // =========================================================================
    // Register writes and clears; a set in the clearing cycle survives
    always_comb
    begin
        wr_cpu_reg = reg_wr && reg_addr == mees_pkg::OFS_CPU_CTRL;
        cpu_clr    = wr_cpu_reg ? (reg_wdata & mees_pkg::ERR_MASK) : 32'h0000_0000;
        // The bus-side register is read-only, so reading it is what clears it.
        bus_clr    = (reg_rd && reg_addr == mees_pkg::OFS_BUS_ERR) ?
                     32'hffff_ffff : 32'h0000_0000;
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            cpu_reg_q <= mees_pkg::RST_REG;
        else if (clk_en)
        begin
            cpu_reg_q <= (((cpu_reg_q & mees_pkg::ERR_MASK) & ~cpu_clr) | cpu_set)
                         | (wr_cpu_reg ? (reg_wdata & mees_pkg::CTRL_WMASK)
                                       : (cpu_reg_q & mees_pkg::CTRL_WMASK));
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            bus_reg_q <= mees_pkg::RST_REG;
        else if (clk_en)
            bus_reg_q <= (bus_reg_q & ~bus_clr) | bus_set;
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            syndrome_q <= 7'h00;
        else if (clk_en && cpu_rd && rd_any)
        begin
            // Logged even when the corrected-read report is suppressed.
            if (rd_single)
                syndrome_q <= rd_syn;
            else
                syndrome_q <= rd_in.word[38:32];
        end
    end

    // =========================================================================
    // Control outputs and summaries
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            translation_enable  <= 1'b0;
            diagnostic_mode_bit <= 1'b0;
            cpu_error_summary   <= 1'b0;
            bus_error_summary   <= 1'b0;
            bus_sum_q           <= 1'b0;
            bus_timeout_force   <= 1'b0;
        end
        else if (clk_en)
        begin
            translation_enable  <= cpu_reg_q[mees_pkg::POS_XLATE_EN];
            diagnostic_mode_bit <= cpu_reg_q[mees_pkg::POS_DIAG];
            cpu_error_summary   <= data_err_cpu || (cpu_reg_q & mees_pkg::ERR_MASK) != 32'h0;
            bus_error_summary   <= data_err_bus || bus_reg_q != 32'h0000_0000;
            bus_sum_q           <= bus_error_summary;
            // One pulse per rising summary, so a held error forces one timeout.
            bus_timeout_force   <= bus_error_summary && !bus_sum_q;
        end
    end

    // =========================================================================
    // Register read port
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            reg_rdata <= 32'h0000_0000;
        else if (clk_en)
        begin
            if (!reg_rd)
                reg_rdata <= 32'h0000_0000;
            else if (reg_addr >= mees_pkg::OFS_MAP_BASE)
                reg_rdata <= {17'h00000, map_q[reg_addr[10:2]]};
            else
            begin
                case (reg_addr)
                    mees_pkg::OFS_SYNDROME: reg_rdata <= {25'h0000000, syndrome_q};
                    mees_pkg::OFS_CPU_CTRL: reg_rdata <= cpu_reg_q;
                    mees_pkg::OFS_BUS_ERR:  reg_rdata <= bus_reg_q;
                    default:                reg_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule : mees_core
`default_nettype wire

//--- core/mees_pkg.sv
// Constants, register layout and carrier types of the memory error-checking block.
// =============================================================================
package mees_pkg;

    // =========================================================================
    // Register map
    localparam logic [11:0] OFS_SYNDROME = 12'h000;
    localparam logic [11:0] OFS_CPU_CTRL = 12'h004;
    localparam logic [11:0] OFS_BUS_ERR  = 12'h008;
    localparam logic [11:0] OFS_MAP_BASE = 12'h800;
    localparam logic [31:0] RST_REG      = 32'h0000_0000;

    // =========================================================================
    // Field positions
    localparam int POS_UNCORR      = 31;
    localparam int POS_CORR        = 30;
    localparam int POS_FORCE_PAR   = 29;
    localparam int POS_SUPPRESS    = 28;
    localparam int POS_XLATE_EN    = 27;
    localparam int POS_DIAG        = 26;
    localparam int POS_CORRECTION_DISABLE     = 25;
    localparam int POS_MODIFY      = 23;
    localparam int POS_DENIED      = 22;
    localparam int POS_MISS        = 21;
    localparam int POS_ILLEGAL     = 20;
    localparam int POS_PAGE_CROSS  = 19;
    localparam int POS_ADAPTER     = 18;
    localparam int POS_BUS_BUSY    = 17;
    localparam int POS_MISSING     = 16;
    localparam int POS_PARITY      = 15;
    localparam int POS_INVALID     = 14;
    localparam logic [31:0] CTRL_WMASK = 32'h3e00_007f;
    localparam logic [31:0] ERR_MASK   = 32'hc0ff_c000;

    // =========================================================================
    // Address space
    localparam logic [23:0] IO_BASE      = 24'h800000;
    localparam logic [23:0] ADAPTER_BASE = 24'hf40000;
    localparam int          MODULE_SHIFT = 20;
    localparam logic [2:0]  MAX_MODULES  = 3'h5;
    localparam int          MAP_PAGE_LSB = 9;

    // =========================================================================
    // Carrier types
    typedef struct packed {
        logic        valid;
        logic        from_bus;
        logic        write;
        logic        write_check;
        logic        crosses_page;
        logic        illegal_op;
        logic [23:0] addr;
    } mees_req_t;

    typedef struct packed {
        logic valid;
        logic bus_side;
        logic two_cycle_write;
        logic parity;
        logic miss;
        logic invalid;
        logic no_modify;
        logic denied;
    } mees_xlate_t;

    typedef struct packed {
        logic        valid;
        logic        from_bus;
        logic [1:0]  byte_ofs;
        logic [38:0] word;
    } mees_rd_t;

    typedef struct packed {
        logic        valid;
        logic        abort;
        logic [31:0] data;
    } mees_rdout_t;

    function automatic logic [6:0] mees_check(input logic [31:0] d);
        logic [6:0] c;
        int         n;
        c = 7'h00;
        n = 0;
        for (int v = 0; v < 128; v++)
        begin
            if ($countones(v[6:0]) == 3 && n < 32)
            begin
                if (d[n])
                    c = c ^ v[6:0];
                n++;
            end
        end
        return c;
    endfunction : mees_check

    function automatic logic [31:0] mees_flip(input logic [6:0] s);
        logic [31:0] m;
        int          n;
        m = 32'h0000_0000;
        n = 0;
        for (int v = 0; v < 128; v++)
        begin
            if ($countones(v[6:0]) == 3 && n < 32)
            begin
                if (v[6:0] == s)
                    m[n] = 1'b1;
                n++;
            end
        end
        return m;
    endfunction : mees_flip

endpackage : mees_pkg

//--- verif/mees_array_model.sv
// Behavioural array module facing the core: keeps one stored word and returns it.
`timescale 1ns/100ps
`default_nettype none
module mees_array_model
(
    input  wire logic               sys_clk,
    input  wire logic               arr_wr_valid,
    input  wire logic [38:0]        arr_wr_word,
    input  wire logic               fetch,
    input  wire logic               fetch_bus,
    input  wire logic [1:0]         fetch_ofs,
    input  wire logic [38:0]        flip,
    output var  mees_pkg::mees_rd_t rd_in
);
    logic [38:0] cell_q;

    always_ff @(posedge sys_clk)
    begin
        if (arr_wr_valid)
            cell_q <= arr_wr_word;
    end

    always_ff @(posedge sys_clk)
    begin
        rd_in.valid    <= fetch;
        rd_in.from_bus <= fetch_bus;
        rd_in.byte_ofs <= fetch_ofs;
        rd_in.word     <= fetch ? cell_q ^ flip : ~cell_q;
    end
endmodule : mees_array_model
`default_nettype wire

//--- verif/mees_core_properties.sv
// Concurrent checks on the ports of the memory error-checking core.
`timescale 1ns/100ps
`default_nettype none
module mees_core_properties
(
    input wire logic                  sys_clk,
    input wire logic                  rstn,
    input wire logic                  clk_en,
    input wire logic [11:0]           reg_addr,
    input wire logic [31:0]           reg_wdata,
    input wire logic                  reg_wr,
    input wire logic                  reg_rd,
    input wire logic [31:0]           reg_rdata,
    input wire logic                  wr_valid,
    input wire logic [31:0]           wr_data,
    input wire logic                  arr_wr_valid,
    input wire logic [38:0]           arr_wr_word,
    input wire mees_pkg::mees_rd_t    rd_in,
    input wire mees_pkg::mees_rdout_t rd_out,
    input wire mees_pkg::mees_req_t   req,
    input wire logic                  cpu_req,
    input wire logic                  bus_req,
    input wire logic                  bus_active,
    input wire logic                  cpu_grant,
    input wire logic                  map_valid,
    input wire logic [17:0]           map_addr,
    input wire logic                  map_phys_valid,
    input wire logic [23:0]           map_phys_addr,
    input wire logic                  req_io_region,
    input wire logic [1:0]            req_bank,
    input wire logic                  translation_enable,
    input wire logic                  diagnostic_mode_bit,
    input wire logic                  cpu_error_summary,
    input wire logic                  bus_error_summary,
    input wire logic                  bus_timeout_force
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn || !clk_en);

    // ========
    // Sequences
    sequence s_ctrl_wr;
        reg_wr && reg_addr == mees_pkg::OFS_CPU_CTRL;
    endsequence
    sequence s_bad_read(logic bus);
        rd_out.valid && rd_out.abort && $past(rd_in.from_bus) == bus;
    endsequence

    // ========
    // Assertions
    chk_store_word: assert property (wr_valid |=> arr_wr_valid && arr_wr_word[31:0] == $past(wr_data))
        else $error("stored longword differs from write data");
    chk_read_answer: assert property (rd_in.valid |=> rd_out.valid)
        else $error("read word not answered");
    chk_cpu_summary: assert property (s_bad_read(1'b0) |-> cpu_error_summary)
        else $error("processor summary missing");
    chk_bus_summary: assert property (s_bad_read(1'b1) |-> bus_error_summary)
        else $error("bus summary missing");
    chk_timeout_pulse: assert property ($rose(bus_error_summary) |=> bus_timeout_force ##1 !bus_timeout_force)
        else $error("bus timeout not a single pulse");
    chk_syndrome_width: assert property (reg_rd && reg_addr == mees_pkg::OFS_SYNDROME |=> reg_rdata[31:7] == 25'h0)
        else $error("syndrome register upper bits set");
    chk_cpu_grant: assert property (cpu_grant |-> $past(cpu_req) && !$past(bus_req) && !$past(bus_active))
        else $error("processor granted while bus in use");
    chk_mode_copies: assert property (s_ctrl_wr |=> ##1 translation_enable == $past(reg_wdata[27], 2)
        && diagnostic_mode_bit == $past(reg_wdata[26], 2))
        else $error("mode outputs do not follow control");
    chk_map_low: assert property (map_valid |=> map_phys_valid && map_phys_addr[8:0] == $past(map_addr[8:0]))
        else $error("map offset not kept");
    chk_region_decode: assert property (req.valid |=> req_io_region == ($past(req.addr) >= mees_pkg::IO_BASE)
        && req_bank == $past(req.addr[19:18]))
        else $error("address decode wrong");
endmodule : mees_core_properties

bind mees_core mees_core_properties u_props (.*);
`default_nettype wire

//--- verif/tb_top.sv
// Self-checking bench for the memory error-checking core.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic                  sys_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic                  wr_valid = 1'b0, map_valid = 1'b0, fetch = 1'b0, fetch_bus = 1'b0;
    logic                  cpu_req = 1'b0, bus_req = 1'b0, bus_active = 1'b0, clk_en = 1'b1;
    logic [1:0]            fetch_ofs = 2'h0;
    logic [38:0]           flip = 39'h0;
    logic [11:0]           reg_addr = 12'h000;
    logic [31:0]           reg_wdata = 32'h0, wr_data = 32'h0, reg_rdata;
    logic [17:0]           map_addr = 18'h0;
    logic [2:0]            modules_installed = 3'h5;
    logic [38:0]           arr_wr_word;
    logic [23:0]           map_phys_addr;
    logic [1:0]            req_bank;
    logic                  arr_wr_valid, cpu_grant, bus_grant, map_phys_valid, req_io_region;
    logic                  translation_enable, diagnostic_mode_bit, cpu_error_summary;
    logic                  bus_error_summary, bus_timeout_force;
    mees_pkg::mees_rd_t    rd_in;
    mees_pkg::mees_rdout_t rd_out;
    mees_pkg::mees_req_t   req = '0;
    mees_pkg::mees_xlate_t xlate = '0;
    int                    n_mismatch = 0, compares = 0;
    localparam logic [31:0] word_a = 32'h1234_5678;
    localparam logic [11:0] syn = mees_pkg::OFS_SYNDROME, ctl = mees_pkg::OFS_CPU_CTRL;

    always #12.5 sys_clk = ~sys_clk;

    mees_core dut (.*);
    mees_array_model u_array (.*);

    // ========
    // Shared tasks
    task automatic check(input logic [38:0] seen, exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    function automatic logic [6:0] col(input int n);
        int k;
        k = 0;
        for (int v = 7; v < 128; v++)
            if ($countones(v) == 3 && k++ == n)
                return v[6:0];
        return 7'h00;
    endfunction : col

    function automatic logic [6:0] ecc(input logic [31:0] d);
        ecc = 7'h00;
        for (int n = 0; n < 32; n++)
            if (d[n])
                ecc ^= col(n);
    endfunction : ecc

    task automatic reg_write(input logic [11:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_chk(input logic [11:0] a, input logic [31:0] exp);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        check(reg_rdata, exp);
        @(posedge sys_clk);
    endtask : reg_chk

    task automatic store(input logic [31:0] d, input logic [6:0] c);
        wr_data  <= d;
        wr_valid <= 1'b1;
        @(posedge sys_clk);
        wr_valid <= 1'b0;
        @(negedge sys_clk);
        check(arr_wr_word, {c, d});
        @(posedge sys_clk);
    endtask : store

    task automatic arr_read(input logic bus, input logic [1:0] o, input logic [38:0] f,
                            input logic [31:0] exp, input logic ab);
        fetch     <= 1'b1;
        fetch_bus <= bus;
        fetch_ofs <= o;
        flip      <= f;
        @(posedge sys_clk);
        fetch <= 1'b0;
        @(posedge sys_clk);
        @(negedge sys_clk);
        check({rd_out.valid, rd_out.abort}, {1'b1, ab});
        if (!ab)
            check(rd_out.data, exp);
        @(posedge sys_clk);
    endtask : arr_read

    task automatic event_pulse(input mees_pkg::mees_req_t r, input mees_pkg::mees_xlate_t x);
        req   <= r;
        xlate <= x;
        @(posedge sys_clk);
        req   <= '0;
        xlate <= '0;
        @(posedge sys_clk);
    endtask : event_pulse

    // ========
    // Scenarios
    task automatic t_ecc_paths;
        store(word_a, ecc(word_a));
        for (int o = 0; o < 4; o++)
            arr_read(1'b0, 2'(o), 39'h0, 32'({word_a, word_a} >> (8 * o)), 1'b0);
        arr_read(1'b0, 2'h0, 39'h20, word_a, 1'b0);
        check(cpu_error_summary, 1'b1);
        reg_chk(syn, {25'h0, col(5)});
        reg_chk(ctl, 32'h4000_0000);
        reg_write(ctl, 32'h5000_0000);
        arr_read(1'b0, 2'h0, 39'h80, word_a, 1'b0);
        reg_chk(syn, {25'h0, col(7)});
        reg_chk(ctl, 32'h1000_0000);
        reg_write(ctl, 32'h0200_0000);
        arr_read(1'b0, 2'h0, 39'h80, word_a ^ 32'h80, 1'b0);
        reg_write(ctl, 32'h0);
        arr_read(1'b0, 2'h0, 39'h3, word_a, 1'b1);
        reg_chk(syn, {25'h0, ecc(word_a)});
        reg_chk(ctl, 32'h8000_0000);
        reg_write(ctl, 32'hc000_0000);
        arr_read(1'b1, 2'h0, 39'h3, word_a, 1'b1);
        check(bus_error_summary, 1'b1);
        @(negedge sys_clk);
        check(bus_timeout_force, 1'b1);
        @(posedge sys_clk);
        reg_chk(mees_pkg::OFS_BUS_ERR, 32'h8000_0000);
        reg_chk(mees_pkg::OFS_BUS_ERR, 32'h0);
    endtask : t_ecc_paths

    task automatic t_control;
        reg_write(syn, 32'hffff_ffff);
        reg_chk(syn, {25'h0, ecc(word_a)});
        reg_write(ctl, 32'hffff_ffff);
        reg_chk(ctl, mees_pkg::CTRL_WMASK);
        check({diagnostic_mode_bit, translation_enable}, 2'h3);
        store(word_a, 7'h7f);
        reg_write(ctl, 32'h2000_0000);
        event_pulse('0, 8'h80);
        reg_chk(ctl, 32'h2000_8000);
        reg_write(ctl, 32'h0800_8000);
        event_pulse('0, 8'h8f);
        reg_chk(ctl, 32'h08e0_4000);
        event_pulse('0, 8'hf4);
        reg_chk(mees_pkg::OFS_BUS_ERR, 32'h0000_c000);
        reg_write(ctl, 32'h00e0_4000);
        clk_en <= 1'b0;
        reg_write(ctl, 32'h0000_007f);
        clk_en <= 1'b1;
        reg_chk(ctl, 32'h0);
    endtask : t_control

    task automatic t_requests;
        modules_installed <= 3'h1;
        event_pulse({6'h21, 24'h00_1000}, '0);
        event_pulse({6'h2e, 24'h00_1000}, '0);
        event_pulse({6'h20, 24'h3c_0000}, '0);
        check({req_io_region, req_bank}, 3'h3);
        event_pulse({6'h20, 24'hf4_0000}, '0);
        bus_active <= 1'b1;
        event_pulse({6'h20, 24'h80_0000}, '0);
        check(req_io_region, 1'b1);
        reg_chk(ctl, 32'h001f_0000);
        cpu_req <= 1'b1;
        repeat (2) @(posedge sys_clk);
        check({bus_grant, cpu_grant}, 2'h0);
        bus_active <= 1'b0;
        repeat (2) @(posedge sys_clk);
        check({bus_grant, cpu_grant}, 2'h1);
        bus_req <= 1'b1;
        repeat (2) @(posedge sys_clk);
        check({bus_grant, cpu_grant}, 2'h2);
        reg_write(12'h80c, 32'h0000_1234);
        map_addr  <= {9'h003, 9'h0ab};
        map_valid <= 1'b1;
        @(posedge sys_clk);
        map_valid <= 1'b0;
        @(negedge sys_clk);
        check(map_phys_addr, {15'h1234, 9'h0ab});
        @(posedge sys_clk);
    endtask : t_requests

    task automatic conclude;
        $display("mismatches %0d comparisons %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude

    initial
    begin
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        for (int a = 0; a < 16; a += 4)
            reg_chk(12'(a), 32'h0);
        t_ecc_paths;
        t_control;
        t_requests;
        conclude;
    end

    initial
    begin
        #(25 * 20000);
        n_mismatch++;
        conclude;
    end
endmodule : tb_top
`default_nettype wire
